//--- common/btw_consts.svh
// Contract
// - Reset loads control with zero: watchdog on, counter clock oscillator/4096.
// - Watchdog reset disabled only while control bits 7..4 hold 1010.
// - Any other upper nibble keeps watchdog enabled; overflow then resets system.
// - Writing one to control bit 1 clears the basic counter at any time.
// - Writing one to control bit 0 clears both prescalers, basic and general-purpose.
// - Carry out of counter bit 7 is overflow; enabled watchdog then resets.
// - Counter clock is oscillator divided by 4096, 1024 or 128, chosen by control.
// - Basic counter is an 8-bit register, readable, not writable.
// - Stop mode left by reset or interrupt; counting at /4096 or preset rate.
// - CPU clock gated off during stabilization; released when counter bit 4 sets.
`ifndef BTW_CONSTS_SVH
`define BTW_CONSTS_SVH

`define BTW_IDX_CTRL 8'hDC
`define BTW_IDX_COUNT 8'hDD
`define BTW_ADDR_CTRL ({`BTW_IDX_CTRL, 2'b00})
`define BTW_ADDR_COUNT ({`BTW_IDX_COUNT, 2'b00})
`define BTW_ADDR_W 10

`define BTW_CTRL_RESET 8'h00
`define BTW_COUNT_RESET 8'h00
`define BTW_SIG_HI 7
`define BTW_SIG_LO 4
`define BTW_SEL_HI 3
`define BTW_SEL_LO 2
`define BTW_BIT_CNT_CLR 1
`define BTW_BIT_DIV_CLR 0
`define BTW_SIG_OFF 4'hA

`define BTW_SEL_4096 2'h0
`define BTW_SEL_1024 2'h1
`define BTW_SEL_128 2'h2
`define BTW_DIV_4096 4096
`define BTW_DIV_1024 1024
`define BTW_DIV_128 128
`define BTW_DIV_W 12

`define BTW_CNT_MAX 8'hFF
`define BTW_STAB_BIT 4

`endif

//--- common/btw_pkg.sv
package btw_pkg;

    typedef enum logic [1:0] {
        BTW_STAB,
        BTW_RUN,
        BTW_STOP
    } btw_phase_t;

    typedef struct packed {
        logic [11:0] div;
    } btw_div_t;

    typedef struct packed {
        btw_phase_t phase;
        logic [3:0] sig;
        logic [1:0] sel;
        logic [7:0] cnt;
        logic div_clr;
        logic wdt_rst;
        logic cpu_clk_en;
        logic wr_pend;
        logic wr_ctrl;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } btw_state_t;

endpackage

//--- verilog/btw_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "btw_consts.svh"

module btw_prescaler #(
    parameter int DIV_A = `BTW_DIV_4096,
    parameter int DIV_B = `BTW_DIV_1024,
    parameter int DIV_C = `BTW_DIV_128
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clear,
    input wire logic run,
    input wire logic [1:0] sel,
    output logic tick
);

    btw_pkg::btw_div_t s_r;
    btw_pkg::btw_div_t s_nxt;
    logic [11:0] mask;

    always_comb begin
        if (sel == `BTW_SEL_4096) begin
            mask = 12'(DIV_A - 1);
        end else if (sel == `BTW_SEL_1024) begin
            mask = 12'(DIV_B - 1);
        end else begin
            mask = 12'(DIV_C - 1);
        end
    end

    // one tick every ratio cycles of the shared divider chain
    assign tick = run && !clear && ((s_r.div & mask) == mask);

    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt.div = 12'h000;
        end else if (run) begin
            s_nxt.div = s_r.div + 12'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule
`default_nettype wire

//--- verilog/btw_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "btw_consts.svh"

module btw_top #(
    parameter int DIV_A = `BTW_DIV_4096,
    parameter int DIV_B = `BTW_DIV_1024,
    parameter int DIV_C = `BTW_DIV_128
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic stop_req,
    input wire logic ext_irq,
    output logic cpu_clk_en,
    output logic wdt_reset,
    output logic gp_prescaler_clear
);

    btw_pkg::btw_state_t s_r;
    btw_pkg::btw_state_t s_nxt;
    logic tick;
    logic run;
    logic addr_phase;
    logic cnt_clear;
    logic wd_on;
    logic [`BTW_ADDR_W-1:0] aoff;

    function automatic logic [1:0] decode(input logic [`BTW_ADDR_W-1:0] a);
        if (a == `BTW_ADDR_CTRL) begin
            decode = 2'h1;
        end else if (a == `BTW_ADDR_COUNT) begin
            decode = 2'h2;
        end else begin
            decode = 2'h0;
        end
    endfunction

    // the prescaler is held while the oscillator is stopped
    assign run = (s_r.phase != btw_pkg::BTW_STOP);

    btw_prescaler #(
        .DIV_A(DIV_A),
        .DIV_B(DIV_B),
        .DIV_C(DIV_C)
    ) btw_prescaler_i (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .clear(s_r.div_clr),
        .run(run),
        .sel(s_r.sel),
        .tick(tick)
    );

    assign addr_phase = hsel && htrans[1] && hready;
    assign aoff = haddr[`BTW_ADDR_W-1:0];
    assign wd_on = (s_r.sig != `BTW_SIG_OFF);

    always_comb begin
        s_nxt = s_r;
        cnt_clear = 1'b0;
        s_nxt.div_clr = 1'b0;
        s_nxt.wdt_rst = 1'b0;
        s_nxt.wr_pend = 1'b0;
        s_nxt.wr_ctrl = 1'b0;
        s_nxt.hreadyout = 1'b1;
        s_nxt.hresp = 1'b0;

        // data phase of a write; only the control register takes data
        if (s_r.wr_pend && s_r.wr_ctrl) begin
            s_nxt.sig = hwdata[`BTW_SIG_HI:`BTW_SIG_LO];
            s_nxt.sel = hwdata[`BTW_SEL_HI:`BTW_SEL_LO];
            // clear bits are never stored, so they read back zero
            if (hwdata[`BTW_BIT_CNT_CLR]) begin
                cnt_clear = 1'b1;
            end
            if (hwdata[`BTW_BIT_DIV_CLR]) begin
                s_nxt.div_clr = 1'b1;
            end
        end

        // counting runs in stabilization and normal operation alike
        if (run && tick) begin
            if (s_r.cnt == `BTW_CNT_MAX) begin
                // carry out of bit 7
                s_nxt.cnt = 8'h00;
                if (wd_on) begin
                    s_nxt.wdt_rst = 1'b1;
                end
            end else begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
        end

        case (s_r.phase)
            btw_pkg::BTW_STAB: begin
                s_nxt.cpu_clk_en = 1'b0;
                if (s_r.cnt[`BTW_STAB_BIT]) begin
                    s_nxt.phase = btw_pkg::BTW_RUN;
                    s_nxt.cpu_clk_en = 1'b1;
                end
            end
            btw_pkg::BTW_RUN: begin
                if (stop_req) begin
                    s_nxt.phase = btw_pkg::BTW_STOP;
                    s_nxt.cpu_clk_en = 1'b0;
                end
            end
            btw_pkg::BTW_STOP: begin
                s_nxt.cpu_clk_en = 1'b0;
                // wake restarts stabilization at the preset ratio
                if (ext_irq) begin
                    s_nxt.phase = btw_pkg::BTW_STAB;
                    s_nxt.cnt = 8'h00;
                end
            end
            default: begin
                s_nxt.phase = btw_pkg::BTW_STAB;
                s_nxt.cpu_clk_en = 1'b0;
            end
        endcase

        // a software clear beats a tick in the same cycle
        if (cnt_clear) begin
            s_nxt.cnt = 8'h00;
        end

        // address phase; read data is taken from the next state so a
        // read right behind a write already sees the written value
        if (addr_phase) begin
            if (hwrite) begin
                s_nxt.wr_pend = 1'b1;
                s_nxt.wr_ctrl = (decode(aoff) == 2'h1);
                s_nxt.hrdata = 32'h0000_0000;
            end else if (decode(aoff) == 2'h1) begin
                s_nxt.hrdata = {24'h00_0000, s_nxt.sig, s_nxt.sel, 2'h0};
            end else if (decode(aoff) == 2'h2) begin
                s_nxt.hrdata = {24'h00_0000, s_nxt.cnt};
            end else begin
                s_nxt.hrdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_r.phase <= btw_pkg::BTW_STAB;
            s_r.sig <= 4'(`BTW_CTRL_RESET >> `BTW_SIG_LO);
            s_r.sel <= `BTW_SEL_4096;
            s_r.cnt <= `BTW_COUNT_RESET;
            s_r.div_clr <= 1'b0;
            s_r.wdt_rst <= 1'b0;
            s_r.cpu_clk_en <= 1'b0;
            s_r.wr_pend <= 1'b0;
            s_r.wr_ctrl <= 1'b0;
            s_r.hrdata <= 32'h0000_0000;
            s_r.hreadyout <= 1'b1;
            s_r.hresp <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.hrdata;
    assign hreadyout = s_r.hreadyout;
    assign hresp = s_r.hresp;
    assign cpu_clk_en = s_r.cpu_clk_en;
    assign wdt_reset = s_r.wdt_rst;
    // general-purpose timer prescaler shares the divider clear
    assign gp_prescaler_clear = s_r.div_clr;

    // hsize is accepted as given: only whole-word transfers are used
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:`BTW_ADDR_W], htrans[0]};

endmodule
`default_nettype wire

//--- sim/btw_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "btw_consts.svh"
module btw_checker (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic stop_req,
    input wire logic cpu_clk_en,
    input wire logic wdt_reset,
    input wire logic gp_prescaler_clear
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    logic ctrl_acc;
    assign ctrl_acc = hsel && htrans[1] && hready && (haddr[9:0] == `BTW_ADDR_CTRL);
    chk_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus response not okay");
    chk_data_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_ctrl_strobes: assert property (ctrl_acc && !hwrite |=> hrdata[1:0] == 2'h0)
        else $error("clear strobes read back set");
    chk_div_cause: assert property (ctrl_acc && hwrite ##1 hwdata[0] |=> gp_prescaler_clear)
        else $error("divider clear not passed on");
    chk_div_pulse: assert property (gp_prescaler_clear |=> !gp_prescaler_clear)
        else $error("divider clear longer than one cycle");
    chk_wdt_pulse: assert property (wdt_reset |=> !wdt_reset)
        else $error("watchdog reset longer than one cycle");
    chk_stop_gate: assert property (stop_req && cpu_clk_en |=> !cpu_clk_en)
        else $error("cpu clock not gated in stop");
    chk_stab_min: assert property ($rose(cpu_clk_en) |-> $past(cpu_clk_en, 16) == 1'b0)
        else $error("stabilization interval too short");
    cover property (wdt_reset);
    cover property ($rose(cpu_clk_en));
    cover property (gp_prescaler_clear);
endmodule
bind btw_top btw_checker btw_checker_i (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stop_req(stop_req),
    .cpu_clk_en(cpu_clk_en), .wdt_reset(wdt_reset), .gp_prescaler_clear(gp_prescaler_clear));
`default_nettype wire

//--- sim/tb_basic_timer_watchdog_stabilizer.sv
`timescale 1ns/10ps
`default_nettype none
`include "btw_consts.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("Error %0t got %h want %h", $time, (a), (b)); end end
module tb_basic_timer_watchdog_stabilizer;
    logic clk_sys = 0, nrst = 0, hsel = 0, hwrite = 0, stop_req = 0, ext_irq = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, cpu_clk_en, wdt_reset, gp_prescaler_clear;
    int mismatches = 0, compares = 0, cyc = 0, wdt_seen = 0, n, w0;
    assign hready = hreadyout;
    // short ratios keep the run small; select 00 ticks every 8 cycles
    btw_top #(.DIV_A(8), .DIV_B(4), .DIV_C(2)) btw_top_i (.clk_sys(clk_sys), .nrst(nrst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .stop_req(stop_req), .ext_irq(ext_irq), .cpu_clk_en(cpu_clk_en),
        .wdt_reset(wdt_reset), .gp_prescaler_clear(gp_prescaler_clear));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (wdt_reset === 1'b1) wdt_seen <= wdt_seen + 1;
        if (cyc > 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic do_reset;
        nrst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask
    task automatic wait_run;
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 5000) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    initial begin
        do_reset();
        xfer(0, `BTW_ADDR_CTRL, 8'h00);
        `CHK(rd[7:0], `BTW_CTRL_RESET)
        wait_run();
        `CHK(n inside {[126:134]}, 1'b1)
        xfer(0, `BTW_ADDR_COUNT, 8'h00);
        `CHK(rd[7:4], 4'h1)
        $display("stabilization after reset done");
        n = 0;
        while (wdt_seen == 0 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(wdt_seen, 1)
        $display("watchdog overflow done");
        do_reset();
        wait_run();
        w0 = wdt_seen;
        // 8 x 300 cycles outlasts one full /8 overflow period of 2048 cycles
        repeat (8) begin
            xfer(1, `BTW_ADDR_CTRL, 8'h02);
            repeat (300) @(posedge clk_sys);
        end
        `CHK(wdt_seen, w0)
        xfer(0, `BTW_ADDR_COUNT, 8'h00);
        `CHK(rd[7:6], 2'h0)
        xfer(1, `BTW_ADDR_CTRL, 8'hAB);
        xfer(0, `BTW_ADDR_CTRL, 8'h00);
        `CHK(rd, 32'h000000A8)
        repeat (1200) @(posedge clk_sys);
        `CHK(wdt_seen, w0)
        $display("clear and signature done");
        for (int s = 0; s < 3; s++) begin
            xfer(1, `BTW_ADDR_CTRL, {4'hA, 2'(s), 2'b11});
            repeat (10 * (8 >> s)) @(posedge clk_sys);
            xfer(0, `BTW_ADDR_COUNT, 8'h00);
            `CHK(rd[7:0] inside {[8'h09:8'h0B]}, 1'b1)
        end
        xfer(1, `BTW_ADDR_CTRL, 8'hAA);
        xfer(1, `BTW_ADDR_COUNT, 8'hF0);
        xfer(0, `BTW_ADDR_COUNT, 8'h00);
        `CHK(rd[7:4], 4'h0)
        xfer(0, 10'h100, 8'h00);
        `CHK(rd, 32'h00000000)
        $display("ratio and access done");
        @(posedge clk_sys) stop_req <= 1'b1;
        @(posedge clk_sys) stop_req <= 1'b0;
        repeat (20) @(posedge clk_sys);
        `CHK(cpu_clk_en, 1'b0)
        @(posedge clk_sys) ext_irq <= 1'b1;
        @(posedge clk_sys) ext_irq <= 1'b0;
        wait_run();
        `CHK(n inside {[28:38]}, 1'b1)
        $display("stop release done");
        report_and_stop();
    end
endmodule
`default_nettype wire
